/* File: hdl/iefl_defs.svh */
// offsets, field positions and reset values for the interrupt enable/flag block
`ifndef IEFL_DEFS_SVH
`define IEFL_DEFS_SVH
`define IEFL_OFF_CORE_CTRL   12'h000
`define IEFL_OFF_PERIPH_EN   12'h004
`define IEFL_OFF_PERIPH_REQ  12'h008
`define IEFL_OFF_PIN_MASK    12'h00C
`define IEFL_OFF_OPTION      12'h010
`define IEFL_OFF_STATUS      12'h014
`define IEFL_OFF_TIMER0      12'h018
`define IEFL_BIT_GLOBAL_EN   7
`define IEFL_BIT_GROUP_EN    6
`define IEFL_BIT_T0_OVF_EN   5
`define IEFL_BIT_EXTIE       4
`define IEFL_BIT_PCIE        3
`define IEFL_BIT_T0_OVF_FLAG 2
`define IEFL_BIT_EXTIF       1
`define IEFL_BIT_PCIF        0
`define IEFL_BIT_EDGE        6
`define IEFL_RST_CORE        8'h00
`define IEFL_RST_PERIPH      8'h00
`define IEFL_RST_MASK        6'h00
`define IEFL_RST_OPTION      8'hFF
`define IEFL_RESP_OKAY       2'h0
`define IEFL_RESP_SLVERR     2'h2
`endif

/* File: hdl/iefl_pkg.sv */
// types shared by the interrupt enable/flag block
package iefl_pkg;
  // peripheral event pulses, bit order matches the peripheral registers
  typedef struct packed {
    logic eeprom_write_done;
    logic conversion_done;
    logic capcomp;
    logic comparator_two;
    logic comparator_one;
    logic osc_fail;
    logic timer2_match;
    logic timer1_overflow;
  } iefl_periph_ev_t;

  // capture/compare unit mode
  typedef enum logic [1:0] {
    IEFL_CC_CAPTURE = 2'b00,
    IEFL_CC_COMPARE = 2'b01,
    IEFL_CC_PWM     = 2'b10,
    IEFL_CC_OFF     = 2'b11
  } iefl_cc_mode_t;

  // read channel state
  typedef enum logic [0:0] {
    IEFL_RD_IDLE = 1'b0,
    IEFL_RD_RESP = 1'b1
  } iefl_rd_state_t;
endpackage : iefl_pkg

/* File: hdl/iefl_core.sv */
// interrupt enable and flag registers with an AXI4-Lite slave
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "iefl_defs.svh"

module iefl_core (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // axi4-lite write address and data
  input  wire logic [11:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // event sources, same clock, one-cycle pulses, and the capture/compare mode level cc_mode
  input  wire logic                    timer0_tick,
  input  wire iefl_pkg::iefl_periph_ev_t periph_ev,
  input  wire iefl_pkg::iefl_cc_mode_t cc_mode,
  // asynchronous pins
  input  wire logic                    external_irq_pin,
  input  wire logic [5:0]              port_a_pins,
  // request to the core and timer value
  output logic                         irq_req,
  output logic [7:0]                   timer0_count
);

  logic [7:0] core_interrupt_control;
  logic [7:0] peripheral_interrupt_enable;
  logic [7:0] peripheral_interrupt_request;
  logic [5:0] pin_change_enable_mask;
  logic [7:0] option_reg;
  logic       ext_s1;
  logic       ext_s2;
  logic       ext_d;
  logic [5:0] port_s1;
  logic [5:0] port_s2;
  logic [5:0] port_d;
  logic       prim_valid;
  logic       ext_event;
  logic       port_event;
  logic       timer0_roll;
  logic [7:0] periph_set;
  logic       aw_held;
  logic       w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic       wr_go;
  logic       wr_hit;
  logic [7:0] next_rdata;
  logic       rd_hit;
  iefl_pkg::iefl_rd_state_t rd_state;

  // address decode shared by read and write
  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == `IEFL_OFF_CORE_CTRL) || (a == `IEFL_OFF_PERIPH_EN) ||
                  (a == `IEFL_OFF_PERIPH_REQ) || (a == `IEFL_OFF_PIN_MASK) ||
                  (a == `IEFL_OFF_OPTION) || (a == `IEFL_OFF_STATUS) ||
                  (a == `IEFL_OFF_TIMER0);
  endfunction : addr_mapped

  // two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge clk) begin
    ext_s1  <= external_irq_pin;
    ext_s2  <= ext_s1;
    port_s1 <= port_a_pins;
    port_s2 <= port_s1;
  end

  // delayed copies for edge detection; prim_valid hides the first sample
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prim_valid <= 1'b0;
      ext_d      <= 1'b0;
      port_d     <= 6'h00;
    end else begin
      prim_valid <= 1'b1;
      ext_d      <= ext_s2;
      port_d     <= port_s2;
    end
  end

  assign ext_event = prim_valid &&
                     (option_reg[`IEFL_BIT_EDGE] ? (ext_s2 && !ext_d) : (!ext_s2 && ext_d));
  assign port_event = prim_valid && |((port_s2 ^ port_d) & pin_change_enable_mask);

  // timer0 count has no reset; it only counts or takes writes
  always_ff @(posedge clk) begin
    if (wr_go && aw_addr == `IEFL_OFF_TIMER0 && w_strb[0])
      timer0_count <= w_data[7:0];
    else if (timer0_tick)
      timer0_count <= timer0_count + 8'h01;
  end
  assign timer0_roll = timer0_tick && (timer0_count == 8'hFF);

  // capcomp event only in capture or compare mode
  always_comb begin
    periph_set = periph_ev;
    periph_set[5] = periph_ev.capcomp &&
                    (cc_mode == iefl_pkg::IEFL_CC_CAPTURE || cc_mode == iefl_pkg::IEFL_CC_COMPARE);
  end

  // axi write channel capture, address and data in either order
  assign wr_go  = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit = addr_mapped(aw_addr);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `IEFL_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `IEFL_RESP_OKAY : `IEFL_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // core control: enables from software, flags set by hardware
  // flags set regardless of enables; set wins over a software clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      core_interrupt_control <= `IEFL_RST_CORE;
    end else begin
      if (wr_go && aw_addr == `IEFL_OFF_CORE_CTRL && w_strb[0])
        core_interrupt_control <= w_data[7:0];
      if (timer0_roll)
        core_interrupt_control[`IEFL_BIT_T0_OVF_FLAG] <= 1'b1;
      if (ext_event)
        core_interrupt_control[`IEFL_BIT_EXTIF] <= 1'b1;
      if (port_event)
        core_interrupt_control[`IEFL_BIT_PCIF] <= 1'b1;
    end
  end

  // enable bit order follows the event struct
  always_ff @(posedge clk) begin
    if (!rst_b)
      peripheral_interrupt_enable <= `IEFL_RST_PERIPH;
    else if (wr_go && aw_addr == `IEFL_OFF_PERIPH_EN && w_strb[0])
      peripheral_interrupt_enable <= w_data[7:0];
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      peripheral_interrupt_request <= `IEFL_RST_PERIPH;
    else if (wr_go && aw_addr == `IEFL_OFF_PERIPH_REQ && w_strb[0])
      peripheral_interrupt_request <= w_data[7:0] | periph_set;
    else
      peripheral_interrupt_request <= peripheral_interrupt_request | periph_set;
  end

  // pin mask and option register; edge select resets to rising
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_change_enable_mask <= `IEFL_RST_MASK;
      option_reg             <= `IEFL_RST_OPTION;
    end else if (wr_go && w_strb[0]) begin
      if (aw_addr == `IEFL_OFF_PIN_MASK)
        pin_change_enable_mask <= w_data[5:0];
      if (aw_addr == `IEFL_OFF_OPTION)
        option_reg <= w_data[7:0];
    end
  end

  // combined request, registered so the output is a flop
  always_ff @(posedge clk) begin
    if (!rst_b)
      irq_req <= 1'b0;
    else
      irq_req <= core_interrupt_control[`IEFL_BIT_GLOBAL_EN] &&
                 (|(core_interrupt_control[5:3] & core_interrupt_control[2:0]) ||
                  (core_interrupt_control[`IEFL_BIT_GROUP_EN] &&
                   |(peripheral_interrupt_enable & peripheral_interrupt_request)));
  end

  // read mux; status shows the registered irq_req in bit 0
  always_comb begin
    next_rdata = 8'h00;
    unique case (s_axi_araddr)
      `IEFL_OFF_CORE_CTRL:  next_rdata = core_interrupt_control;
      `IEFL_OFF_PERIPH_EN:  next_rdata = peripheral_interrupt_enable;
      `IEFL_OFF_PERIPH_REQ: next_rdata = peripheral_interrupt_request;
      `IEFL_OFF_PIN_MASK:   next_rdata = {2'b00, pin_change_enable_mask};
      `IEFL_OFF_OPTION:     next_rdata = option_reg;
      `IEFL_OFF_STATUS:     next_rdata = {7'h00, irq_req};
      `IEFL_OFF_TIMER0:     next_rdata = timer0_count;
      default:              next_rdata = 8'h00;
    endcase
  end
  assign rd_hit = addr_mapped(s_axi_araddr);

  // read channel: accept, answer next cycle, hold until rready
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_state      <= iefl_pkg::IEFL_RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `IEFL_RESP_OKAY;
    end else begin
      unique case (rd_state)
        iefl_pkg::IEFL_RD_IDLE: begin
          s_axi_arready <= s_axi_arvalid && !s_axi_arready;
          if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, next_rdata};
            s_axi_rresp   <= rd_hit ? `IEFL_RESP_OKAY : `IEFL_RESP_SLVERR;
            rd_state      <= iefl_pkg::IEFL_RD_RESP;
          end
        end
        iefl_pkg::IEFL_RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state     <= iefl_pkg::IEFL_RD_IDLE;
          end
        end
      endcase
    end
  end

endmodule : iefl_core

/* File: dv/iefl_ev_src.sv */
// event source model: one-cycle event pulses on request
`timescale 1ns/10ps
module iefl_ev_src (
  // clock
  input  wire logic                 clk,
  // request from the bench, sel 8 means timer0
  input  wire logic                 fire,
  input  wire logic [3:0]           sel,
  // pulses into the block
  output iefl_pkg::iefl_periph_ev_t periph_ev,
  output logic                      timer0_tick
);
  // pulses last one cycle only, so a flag that is clear later than this shows a latch fault
  always_ff @(posedge clk) begin
    periph_ev   <= iefl_pkg::iefl_periph_ev_t'((fire && sel < 4'h8) ? 8'h01 << sel : 8'h00);
    timer0_tick <= fire && (sel == 4'h8);
  end
endmodule : iefl_ev_src

/* File: dv/iefl_core_sva.sv */
// port assertions for the interrupt enable/flag block
`timescale 1ns/10ps
module iefl_core_sva (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // bus
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // timer and request
  input wire logic        timer0_tick,
  input wire logic        irq_req,
  input wire logic [7:0]  timer0_count
);
  logic armed = 1'b0;
  // count is undefined until software writes it, so keep-checks wait for a first write
  always_ff @(posedge clk) if (s_axi_bvalid && s_axi_bready) armed <= 1'b1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_rst_quiet; disable iff (1'b0) !rst_b |=> !s_axi_bvalid && !s_axi_rvalid && !irq_req; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not cleared by reset");
  property p_t0_keep; disable iff (1'b0) armed && !rst_b |=> timer0_count == $past(timer0_count); endproperty
  a_t0_keep: assert property (p_t0_keep) else $error("timer count lost on reset");
  property p_t0_inc; armed && timer0_tick && !s_axi_awvalid |=> timer0_count == $past(timer0_count) + 8'h01; endproperty
  a_t0_inc: assert property (p_t0_inc) else $error("timer count not advanced");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_ar_lat: assert property (p_ar_lat) else $error("read answer late");
  property p_ar_take; s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready; endproperty
  a_ar_take: assert property (p_ar_take) else $error("read address not taken");
  property p_w_err; s_axi_awvalid && s_axi_awready && s_axi_awaddr > 12'h018
    |-> ##[1:3] (s_axi_bvalid && s_axi_bresp == 2'h2); endproperty
  a_w_err: assert property (p_w_err) else $error("unmapped write not refused");
  property p_r_err; s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h018
    |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0; endproperty
  a_r_err: assert property (p_r_err) else $error("unmapped read not refused");
endmodule : iefl_core_sva

bind iefl_core iefl_core_sva iefl_core_sva_i (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer0_tick, .irq_req, .timer0_count);

/* File: dv/interrupt_enable_flag_logic_bench.sv */
// self-checking bench for the interrupt enable/flag block
`timescale 1ns/10ps
module interrupt_enable_flag_logic_bench;
  logic clk, rst_b, awv, wv, bv, bready, arv, rv, rready, fire, tick, ext_pin, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic aw_rdy, w_rdy, ar_rdy;
  logic [3:0] sel;
  logic [5:0] pins;
  logic [7:0] t0, m, rv8;
  iefl_pkg::iefl_periph_ev_t ev;
  iefl_pkg::iefl_cc_mode_t cc_mode;
  int n_mismatch, num_checks, cyc;

  iefl_core iefl_core_i (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(aw_rdy), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(w_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(ar_rdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rready), .timer0_tick(tick), .periph_ev(ev), .cc_mode(cc_mode),
    .external_irq_pin(ext_pin), .port_a_pins(pins), .irq_req(irq), .timer0_count(t0));
  iefl_ev_src iefl_ev_src_i (.clk(clk), .fire(fire), .sel(sel), .periph_ev(ev), .timer0_tick(tick));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard, well above the length of the sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    {awaddr, wdata, awv, wv, bready} <= {a, 24'h0, d, 3'b111};
    do begin
      @(posedge clk);
      if (aw_rdy === 1'b1) awv <= 1'b0;
      if (w_rdy === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic w(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask : w
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    {araddr, arv, rready} <= {a, 2'b11};
    do begin
      @(posedge clk);
      if (ar_rdy === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask : rd
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, {24'h0, e});
    chk(r, 2'h0);
  endtask : rc
  task automatic pulse(input logic [3:0] s);
    @(posedge clk);
    {fire, sel} <= {1'b1, s};
    @(posedge clk);
    fire <= 1'b0;
  endtask : pulse
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    {rst_b, awv, wv, bready, arv, rready, fire, ext_pin, awaddr, araddr, wdata, sel, pins} = '0;
    cc_mode = iefl_pkg::IEFL_CC_CAPTURE;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    w(12'h018, 8'hFE);
    foreach (rv8[i]) if (i < 5) rc(12'h000 + 12'(4 * i), (i == 4) ? 8'hFF : 8'h00);
    pulse(4'h8);
    rc(12'h018, 8'hFF);
    pulse(4'h8);
    rc(12'h000, 8'h04);
    // flag set with every enable off
    rc(12'h014, 8'h00);
    w(12'h000, 8'hA4);
    rc(12'h014, 8'h01);
    w(12'h000, 8'h24);
    rc(12'h014, 8'h00);
    w(12'h018, 8'h5A);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rc(12'h018, 8'h5A);
    rc(12'h000, 8'h00);
    // each peripheral source against its own enable and the others
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      cc_mode <= (i == 5) ? iefl_pkg::IEFL_CC_COMPARE : iefl_pkg::IEFL_CC_CAPTURE;
      pulse(4'(i));
      rc(12'h008, m);
      w(12'h000, 8'hC0);
      w(12'h004, ~m);
      rc(12'h014, 8'h00);
      w(12'h004, m);
      rc(12'h014, 8'h01);
      w(12'h000, 8'h80);
      rc(12'h014, 8'h00);
      w(12'h008, 8'h00);
      w(12'h004, 8'h00);
    end
    cc_mode <= iefl_pkg::IEFL_CC_PWM;
    pulse(4'h5);
    rc(12'h008, 8'h00);
    cc_mode <= iefl_pkg::IEFL_CC_OFF;
    pulse(4'h5);
    rc(12'h008, 8'h00);
    // rising edge by default, then falling
    ext_pin <= 1'b1;
    repeat (6) @(posedge clk);
    rc(12'h000, 8'h82);
    w(12'h010, 8'hBF);
    // clear the flag before the next event
    w(12'h000, 8'h00);
    ext_pin <= 1'b0;
    repeat (6) @(posedge clk);
    rc(12'h000, 8'h02);
    w(12'h000, 8'h00);
    ext_pin <= 1'b1;
    repeat (6) @(posedge clk);
    rc(12'h000, 8'h00);
    w(12'h00C, 8'h01);
    pins <= 6'h02;
    repeat (6) @(posedge clk);
    rc(12'h000, 8'h00);
    pins <= 6'h03;
    repeat (6) @(posedge clk);
    rc(12'h000, 8'h01);
    wr(12'h020, 8'h11, r);
    chk(r, 2'h2);
    rd(12'h020, d, r);
    chk(d, 32'h0000_0000);
    chk({30'h0, r}, 32'h0000_0002);
    wrap_up();
  end
endmodule : interrupt_enable_flag_logic_bench
